/* File: design/usbms_dev.sv */
/*
  device end: role/option register and per-endpoint setup arrival flags,
  plus the link-side effects of those options.
  assumes link-side inputs are on sys_clk_i; registers via usbms_if.dev.
*/
// The address map and the address-and-strobe port were chosen for this implementation.
// How it works
// - host plus stream-off: launch only when fifo full
// - device plus stream-off: no double priming
// - high-speed device stream-off answers every packet NYET
// - lockout mode bit one turns setup lockouts off
// - byte order bit picks little or big endian
// - register and structure layout ignore byte order
// - software must set the byte order bit
// - role field accepts one write per reset
// - software resets controller before changing role
// - role codes: idle, reserved, device, host
// - reset gives idle; software then sets role
// - setup on endpoint sets its arrival flag
// - writing one clears arrival flag after reading
// - arrival flags act only in device role
// - software should answer setups promptly
`timescale 1ns/1ps
module usbms_dev #(
  parameter int EP_W = 2
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  usbms_if.dev bus,
  input wire logic hs_mode_i,
  input wire logic tx_pkt_req_i,
  input wire logic tx_fifo_full_i,
  input wire logic rx_pkt_i,
  input wire logic setup_rx_i,
  input wire logic [EP_W-1:0] setup_ep_i,
  input wire logic [31:0] buf_data_i,
  output logic role_dev_o,
  output logic role_host_o,
  output logic tx_launch_o,
  output logic dbl_prime_en_o,
  output logic nyet_o,
  output logic lockout_on_o,
  output logic [3:0] setup_pending_o,
  output logic [31:0] buf_data_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] role;
  logic role_locked;
  logic stream_off_bit;
  logic setup_lockout_mode_bit;
  logic byte_order_select;
  logic [3:0] setup_flags;
  logic [31:0] rdata;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // controller reset from the command register clears like a power reset, except rdata, which only sys_rst_i clears
  wire rst_all = sys_rst_i | bus.ctl_reset;
  wire wr_cfg = bus.bus_wr && (bus.bus_addr == usbms_pkg::CFG_OFF);
  wire wr_saf = bus.bus_wr && (bus.bus_addr == usbms_pkg::SAF_OFF);
  wire rd_cfg = bus.bus_rd && (bus.bus_addr == usbms_pkg::CFG_OFF);
  wire rd_saf = bus.bus_rd && (bus.bus_addr == usbms_pkg::SAF_OFF);
  wire [1:0] wr_role = bus.bus_wdata[usbms_pkg::ROLE_LSB +: 2];
  wire is_dev = (role == usbms_pkg::ROLE_DEV);
  wire is_host = (role == usbms_pkg::ROLE_HOST);
  wire dev_stream_off_bit = is_dev && stream_off_bit;
  wire host_stream_off_bit = is_host && stream_off_bit;

  // set beats clear: an arrival in the ack cycle stays pending
  wire [3:0] set_vec = (setup_rx_i && is_dev) ?
    (4'h1 << setup_ep_i) : 4'h0;
  wire [3:0] clr_vec = wr_saf ?
    bus.bus_wdata[usbms_pkg::NUM_EP-1:0] : 4'h0;
  wire [3:0] next_setup_flags = (setup_flags & ~clr_vec) | set_vec;

  // fixed word layout whatever the byte order bit holds
  wire [31:0] cfg_word = {27'h0, stream_off_bit, setup_lockout_mode_bit,
    byte_order_select, role};
  wire [31:0] saf_word = {28'h0, setup_flags};
  wire [31:0] next_rdata = rd_cfg ? cfg_word :
    rd_saf ? saf_word : 32'h0;

  // only buffer payload is swapped, never registers or descriptors
  wire [31:0] swapped = {buf_data_i[7:0], buf_data_i[15:8],
    buf_data_i[23:16], buf_data_i[31:24]};
  wire [31:0] next_buf = byte_order_select ? swapped : buf_data_i;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      role <= usbms_pkg::ROLE_IDLE;
      role_locked <= 1'b0;
      stream_off_bit <= usbms_pkg::CFG_RESET[usbms_pkg::STREAM_OFF_BIT_BIT];
      setup_lockout_mode_bit <= usbms_pkg::CFG_RESET[usbms_pkg::SETUP_LOCKOUT_MODE_BIT_BIT];
      byte_order_select <= usbms_pkg::CFG_RESET[usbms_pkg::BORD_BIT];
    end else if (wr_cfg) begin
      stream_off_bit <= bus.bus_wdata[usbms_pkg::STREAM_OFF_BIT_BIT];
      setup_lockout_mode_bit <= bus.bus_wdata[usbms_pkg::SETUP_LOCKOUT_MODE_BIT_BIT];
      byte_order_select <= bus.bus_wdata[usbms_pkg::BORD_BIT];
      // later role writes are dropped until the next reset
      if (!role_locked) begin
        role <= wr_role;
        role_locked <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      setup_flags <= usbms_pkg::SAF_RESET;
    end else begin
      setup_flags <= next_setup_flags;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata <= 32'h0;
    end else begin
      rdata <= next_rdata;
    end
  end
  assign bus.bus_rdata = rdata;

  // ----------------------------------------------------------------
  // link-side outputs
  // ----------------------------------------------------------------
  // one short flop per output so each reset value stays in sight
  // costs link time but a full fifo cannot underrun mid-packet
  wire next_tx_launch = tx_pkt_req_i &&
    (!host_stream_off_bit || tx_fifo_full_i);
  // stream-off trades throughput for a single buffer per direction
  wire next_dbl_prime_en = is_dev && !stream_off_bit;
  wire next_nyet = rx_pkt_i && hs_mode_i && dev_stream_off_bit;
  wire next_lockout_on = is_dev && !setup_lockout_mode_bit;
  // flags are hidden from the link outside device role
  wire [3:0] next_setup_pending = is_dev ? setup_flags : 4'h0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      role_dev_o <= 1'b0;
    end else begin
      role_dev_o <= is_dev;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      role_host_o <= 1'b0;
    end else begin
      role_host_o <= is_host;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      tx_launch_o <= 1'b0;
    end else begin
      tx_launch_o <= next_tx_launch;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      dbl_prime_en_o <= 1'b0;
    end else begin
      dbl_prime_en_o <= next_dbl_prime_en;
    end
  end

  // one-cycle pulse for each received packet in high-speed device stream-off
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      nyet_o <= 1'b0;
    end else begin
      nyet_o <= next_nyet;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      lockout_on_o <= 1'b0;
    end else begin
      lockout_on_o <= next_lockout_on;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      setup_pending_o <= 4'h0;
    end else begin
      setup_pending_o <= next_setup_pending;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      buf_data_o <= 32'h0;
    end else begin
      buf_data_o <= next_buf;
    end
  end
endmodule : usbms_dev

/* File: design/usbms_drv.sv */
/*
  driver end: programs the role register and acknowledges setup flags
  on behalf of software, which reaches it over a plain register port.
  assumes read data on usbms_if one cycle after bus_rd.
*/
`timescale 1ns/1ps
module usbms_drv (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  usbms_if.drv bus,
  input wire logic [7:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  usbms_pkg::usbms_drv_state_t state;
  usbms_pkg::usbms_drv_state_t next_state;
  logic [4:0] want_cfg;
  logic cfg_req;
  logic configured;
  logic [3:0] ack_mask;
  logic [3:0] pending;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic ctl_rst;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_setup = sw_wr_i && (sw_addr_i == usbms_pkg::DRV_SETUP_OFF);
  wire wr_ack = sw_wr_i && (sw_addr_i == usbms_pkg::DRV_ACK_OFF);
  wire go = wr_setup && sw_wdata_i[usbms_pkg::DRV_GO_BIT];
  wire busy = (state != usbms_pkg::DS_IDLE) || cfg_req;
  wire [31:0] stat_word = {16'h0, pending, 2'h0, configured, busy,
    3'h0, want_cfg};
  wire [31:0] next_sw_rdata = !sw_rd_i ? 32'h0 :
    (sw_addr_i == usbms_pkg::DRV_SETUP_OFF) ? {27'h0, want_cfg} :
    (sw_addr_i == usbms_pkg::DRV_STAT_OFF) ? stat_word : 32'h0;
  // byte order forced on: the controller misbehaves without it
  wire [31:0] cfg_word = {27'h0, want_cfg} |
    (32'h1 << usbms_pkg::BORD_BIT);
  wire [3:0] next_pending = (pending & ~ack_mask) |
    ((state == usbms_pkg::DS_WAIT) ? bus.bus_rdata[3:0] : 4'h0);

  always_comb begin
    next_state = state;
    unique case (state)
      usbms_pkg::DS_IDLE: begin
        if (cfg_req) begin
          // role is write-once, so a reconfigure needs a reset first
          next_state = configured ? usbms_pkg::DS_RESET :
            usbms_pkg::DS_CFG;
        end else if (ack_mask != 4'h0) begin
          next_state = usbms_pkg::DS_ACK;
        end else if (configured) begin
          next_state = usbms_pkg::DS_POLL;
        end
      end
      usbms_pkg::DS_RESET: next_state = usbms_pkg::DS_CFG;
      usbms_pkg::DS_CFG: next_state = usbms_pkg::DS_IDLE;
      usbms_pkg::DS_POLL: next_state = usbms_pkg::DS_WAIT;
      usbms_pkg::DS_WAIT: next_state = usbms_pkg::DS_IDLE;
      usbms_pkg::DS_ACK: next_state = usbms_pkg::DS_IDLE;
      default: next_state = usbms_pkg::DS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= usbms_pkg::DS_IDLE;
      want_cfg <= 5'h0;
      cfg_req <= 1'b0;
      configured <= 1'b0;
      ack_mask <= 4'h0;
      pending <= 4'h0;
      sw_rdata_o <= 32'h0;
    end else begin
      state <= next_state;
      sw_rdata_o <= next_sw_rdata;
      pending <= next_pending;
      if (go) begin
        want_cfg <= sw_wdata_i[4:0];
        cfg_req <= 1'b1;
      end else if (state == usbms_pkg::DS_IDLE) begin
        cfg_req <= 1'b0;
      end
      if (state == usbms_pkg::DS_CFG) begin
        configured <= 1'b1;
      end
      // only acks flags already seen, i.e. after the setup was read
      if (wr_ack) begin
        ack_mask <= ack_mask | (sw_wdata_i[3:0] & pending);
      end else if (state == usbms_pkg::DS_ACK) begin
        ack_mask <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // link to the device
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      addr <= 8'h0;
      wdata <= 32'h0;
      wr <= 1'b0;
      rd <= 1'b0;
      ctl_rst <= 1'b0;
    end else begin
      wr <= 1'b0;
      rd <= 1'b0;
      ctl_rst <= 1'b0;
      unique case (next_state)
        usbms_pkg::DS_RESET: ctl_rst <= 1'b1;
        usbms_pkg::DS_CFG: begin
          addr <= usbms_pkg::CFG_OFF;
          wdata <= cfg_word;
          wr <= 1'b1;
        end
        usbms_pkg::DS_POLL: begin
          addr <= usbms_pkg::SAF_OFF;
          rd <= 1'b1;
        end
        usbms_pkg::DS_ACK: begin
          addr <= usbms_pkg::SAF_OFF;
          wdata <= {28'h0, ack_mask};
          wr <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
  assign bus.bus_addr = addr;
  assign bus.bus_wdata = wdata;
  assign bus.bus_wr = wr;
  assign bus.bus_rd = rd;
  assign bus.ctl_reset = ctl_rst;
endmodule : usbms_drv

/* File: design/usbms_if.sv */
/*
  register link between the driver end and the mode/setup-status device.
  assumes both ends share sys_clk_i; read data one cycle after bus_rd.
*/
`timescale 1ns/1ps
interface usbms_if;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic ctl_reset;

  modport dev (
    input bus_addr,
    input bus_wdata,
    input bus_wr,
    input bus_rd,
    output bus_rdata,
    input ctl_reset
  );
  modport drv (
    output bus_addr,
    output bus_wdata,
    output bus_wr,
    output bus_rd,
    input bus_rdata,
    output ctl_reset
  );
endinterface : usbms_if

/* File: design/usbms_pkg.sv */
/*
  constants shared by the mode/setup-status device end and the driver end.
  assumes one 50 MHz clock and a synchronous active-high reset.
*/
package usbms_pkg;
  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] SAF_OFF = 8'h04;
  localparam int ROLE_LSB = 0;
  localparam int BORD_BIT = 2;
  localparam int SETUP_LOCKOUT_MODE_BIT_BIT = 3;
  localparam int STREAM_OFF_BIT_BIT = 4;
  localparam int NUM_EP = 4;
  localparam logic [1:0] ROLE_IDLE = 2'h0;
  localparam logic [1:0] ROLE_RSVD = 2'h1;
  localparam logic [1:0] ROLE_DEV = 2'h2;
  localparam logic [1:0] ROLE_HOST = 2'h3;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [3:0] SAF_RESET = 4'h0;
  // ----------------------------------------------------------------
  // driver register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DRV_SETUP_OFF = 8'h00;
  localparam logic [7:0] DRV_ACK_OFF = 8'h04;
  localparam logic [7:0] DRV_STAT_OFF = 8'h08;
  localparam int DRV_GO_BIT = 8;
  localparam int DRV_BUSY_BIT = 8;
  localparam int DRV_DONE_BIT = 9;
  localparam int DRV_PEND_LSB = 12;
  typedef enum logic [5:0] {
    DS_IDLE = 6'h01,
    DS_RESET = 6'h02,
    DS_CFG = 6'h04,
    DS_POLL = 6'h08,
    DS_WAIT = 6'h10,
    DS_ACK = 6'h20
  } usbms_drv_state_t;
endpackage : usbms_pkg

/* File: verification/test_usb_mode_setup_status.sv */
/*
  bench: driver end and device end joined by usbms_if.
  assumes software port strobes one cycle, read data one cycle later.
*/
`timescale 1ns/1ps
module test_usb_mode_setup_status;
  logic sys_clk_i, sys_rst_i, hs_mode_i, tx_pkt_req_i, tx_fifo_full_i;
  logic rx_pkt_i, setup_rx_i, sw_wr_i, sw_rd_i, nyet_o, lockout_on_o;
  logic role_dev_o, role_host_o, tx_launch_o, dbl_prime_en_o;
  logic [1:0] setup_ep_i;
  logic [3:0] setup_pending_o;
  logic [7:0] sw_addr_i;
  logic [31:0] buf_data_i, buf_data_o, sw_wdata_i, sw_rdata_o, d;
  int n_errors, comparisons;
  usbms_if bus_if();
  usbms_dev i_usbms_dev (.sys_clk_i, .sys_rst_i, .bus(bus_if), .hs_mode_i,
    .tx_pkt_req_i, .tx_fifo_full_i, .rx_pkt_i, .setup_rx_i, .setup_ep_i,
    .buf_data_i, .role_dev_o, .role_host_o, .tx_launch_o, .dbl_prime_en_o,
    .nyet_o, .lockout_on_o, .setup_pending_o, .buf_data_o);
  usbms_drv i_usbms_drv (.sys_clk_i, .sys_rst_i, .bus(bus_if), .sw_addr_i,
    .sw_wdata_i, .sw_wr_i, .sw_rd_i, .sw_rdata_o);
  usbms_chk i_usbms_chk (.sys_clk_i, .sys_rst_i,
    .bus_addr(bus_if.bus_addr), .bus_wdata(bus_if.bus_wdata),
    .bus_wr(bus_if.bus_wr), .bus_rdata(bus_if.bus_rdata),
    .ctl_reset(bus_if.ctl_reset), .hs_mode_i, .tx_pkt_req_i,
    .tx_fifo_full_i, .rx_pkt_i, .setup_rx_i, .setup_ep_i, .buf_data_i,
    .role_dev_o, .role_host_o, .tx_launch_o, .dbl_prime_en_o, .nyet_o,
    .lockout_on_o, .setup_pending_o, .buf_data_o);
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task sw_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= v;
    sw_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    sw_wr_i <= 1'b0;
  endtask : sw_write
  task sw_read(input logic [7:0] a);
    @(posedge sys_clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask : sw_read
  task wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_clk
  // busy is polled with a bound so a stuck driver cannot hang the run
  task set_cfg(input logic [4:0] c);
    sw_write(usbms_pkg::DRV_SETUP_OFF, 32'h0000_0100 | {27'h0, c});
    wait_clk(2);
    d = 32'h0000_0100;
    for (int k = 0; k < 40 && d[usbms_pkg::DRV_BUSY_BIT]; k++) begin
      sw_read(usbms_pkg::DRV_STAT_OFF);
    end
    if (d[usbms_pkg::DRV_BUSY_BIT] !== 1'b0) begin
      n_errors++;
      end_sim();
    end else begin
      chk("configured", 32'h1, 32'(d[usbms_pkg::DRV_DONE_BIT]));
      wait_clk(3);
    end
  endtask : set_cfg
  task pulse(input logic [1:0] ep);
    @(posedge sys_clk_i);
    setup_ep_i <= ep;
    setup_rx_i <= 1'b1;
    @(posedge sys_clk_i);
    setup_rx_i <= 1'b0;
  endtask : pulse
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_reset();
    chk("role_dev", 32'h0, 32'(role_dev_o));
    chk("role_host", 32'h0, 32'(role_host_o));
    sw_read(8'h0c);
    chk("unmapped", 32'h0, d);
    @(posedge sys_clk_i);
    buf_data_i <= 32'h1122_3344;
    wait_clk(2);
    chk("buf_little", 32'h1122_3344, buf_data_o);
  endtask : test_reset
  task test_roles();
    for (int i = 1; i < 4; i++) begin
      set_cfg({3'h0, 2'(i)});
      chk("role_dev", 32'(i == 2), 32'(role_dev_o));
      chk("role_host", 32'(i == 3), 32'(role_host_o));
    end
  endtask : test_roles
  task test_setup();
    set_cfg(5'h02);
    chk("dbl_prime", 32'h1, 32'(dbl_prime_en_o));
    chk("lockout", 32'h1, 32'(lockout_on_o));
    @(posedge sys_clk_i);
    buf_data_i <= 32'ha1b2_c3d4;
    wait_clk(2);
    chk("buf_big", 32'hd4c3_b2a1, buf_data_o);
    pulse(2'h2);
    pulse(2'h0);
    wait_clk(3);
    chk("pending", 32'h5, 32'(setup_pending_o));
    wait_clk(12);
    sw_read(usbms_pkg::DRV_STAT_OFF);
    chk("sw_pending", 32'h5, 32'(d[15:12]));
    sw_write(usbms_pkg::DRV_ACK_OFF, 32'h0000_000c);
    wait_clk(12);
    chk("acked", 32'h1, 32'(setup_pending_o));
  endtask : test_setup
  task test_stream();
    set_cfg(5'h1a);
    chk("dbl_prime", 32'h0, 32'(dbl_prime_en_o));
    chk("lockout", 32'h0, 32'(lockout_on_o));
    @(posedge sys_clk_i);
    rx_pkt_i <= 1'b1;
    @(posedge sys_clk_i);
    rx_pkt_i <= 1'b0;
    #1 chk("nyet_full_speed", 32'h0, 32'(nyet_o));
    @(posedge sys_clk_i);
    hs_mode_i <= 1'b1;
    rx_pkt_i <= 1'b1;
    @(posedge sys_clk_i);
    rx_pkt_i <= 1'b0;
    #1 chk("nyet", 32'h1, 32'(nyet_o));
    wait_clk(1);
    chk("nyet_end", 32'h0, 32'(nyet_o));
  endtask : test_stream
  task test_host();
    set_cfg(5'h13);
    @(posedge sys_clk_i);
    tx_pkt_req_i <= 1'b1;
    wait_clk(3);
    chk("launch_early", 32'h0, 32'(tx_launch_o));
    @(posedge sys_clk_i);
    tx_fifo_full_i <= 1'b1;
    wait_clk(2);
    chk("launch_full", 32'h1, 32'(tx_launch_o));
    pulse(2'h1);
    wait_clk(3);
    chk("pending_host", 32'h0, 32'(setup_pending_o));
  endtask : test_host
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    comparisons = 0;
    {sys_rst_i, hs_mode_i, tx_pkt_req_i, tx_fifo_full_i} = 4'h8;
    {rx_pkt_i, setup_rx_i, sw_wr_i, sw_rd_i, setup_ep_i} = 6'h00;
    sw_addr_i = 8'h00;
    sw_wdata_i = 32'h0;
    buf_data_i = 32'h0;
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    wait_clk(1);
    test_reset();
    test_roles();
    test_setup();
    test_stream();
    test_host();
    end_sim();
  end
endmodule : test_usb_mode_setup_status

/* File: verification/usbms_chk_asserts.sv */
/*
  checker for the usbms register link and the device link outputs.
  assumes it sits beside usbms_if, all on sys_clk_i.
*/
`timescale 1ns/1ps
module usbms_chk (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic [31:0] bus_rdata,
  input wire logic ctl_reset,
  input wire logic hs_mode_i,
  input wire logic tx_pkt_req_i,
  input wire logic tx_fifo_full_i,
  input wire logic rx_pkt_i,
  input wire logic setup_rx_i,
  input wire logic [1:0] setup_ep_i,
  input wire logic [31:0] buf_data_i,
  input wire logic role_dev_o,
  input wire logic role_host_o,
  input wire logic tx_launch_o,
  input wire logic dbl_prime_en_o,
  input wire logic nyet_o,
  input wire logic lockout_on_o,
  input wire logic [3:0] setup_pending_o,
  input wire logic [31:0] buf_data_o
);
  // ----------------------------------------------------------------
  // shadow of the role register
  // ----------------------------------------------------------------
  logic [1:0] role_q;
  logic locked_q, stream_off_bit_q, setup_lockout_mode_bit_q, bord_q, was_rst;
  wire cfg_wr = bus_wr && bus_addr == usbms_pkg::CFG_OFF;
  wire saf_wr = bus_wr && bus_addr == usbms_pkg::SAF_OFF;
  wire [31:0] swapped = {buf_data_i[7:0], buf_data_i[15:8],
    buf_data_i[23:16], buf_data_i[31:24]};
  always_ff @(posedge sys_clk_i) begin
    was_rst <= sys_rst_i || ctl_reset;
    if (sys_rst_i || ctl_reset) begin
      role_q <= usbms_pkg::ROLE_IDLE;
      locked_q <= 1'b0;
      {stream_off_bit_q, setup_lockout_mode_bit_q, bord_q} <= 3'h0;
    end else if (cfg_wr) begin
      // options stay writable, only the role locks
      {stream_off_bit_q, setup_lockout_mode_bit_q, bord_q} <= bus_wdata[4:2];
      if (!locked_q) begin
        role_q <= bus_wdata[1:0];
        locked_q <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rdata_rsvd_zero: assert property (
    bus_rdata[31:5] == 27'h0) else $error("reserved read bits set");
  chk_role_decode: assert property (!was_rst |->
    role_dev_o == ($past(role_q) == usbms_pkg::ROLE_DEV) &&
    role_host_o == ($past(role_q) == usbms_pkg::ROLE_HOST))
    else $error("role outputs wrong");
  chk_idle_after_reset: assert property (was_rst |->
    !role_dev_o && !role_host_o) else $error("role not idle");
  chk_reset_first: assert property (
    !(cfg_wr && locked_q)) else $error("role rewritten without reset");
  chk_host_fill: assert property (!was_rst |-> tx_launch_o ==
    ($past(tx_pkt_req_i) && (!(role_host_o && $past(stream_off_bit_q)) ||
    $past(tx_fifo_full_i)))) else $error("launch before fifo full");
  chk_dbl_prime_off: assert property (
    dbl_prime_en_o == (role_dev_o && !$past(stream_off_bit_q)))
    else $error("double priming wrong");
  chk_nyet_answer: assert property (
    nyet_o == (role_dev_o && $past(rx_pkt_i && hs_mode_i && stream_off_bit_q)))
    else $error("nyet wrong");
  chk_lockout_mode: assert property (
    lockout_on_o == (role_dev_o && !$past(setup_lockout_mode_bit_q)))
    else $error("lockout wrong");
  chk_byte_order: assert property (!was_rst |->
    buf_data_o == ($past(bord_q) ? $past(swapped) : $past(buf_data_i)))
    else $error("buffer byte order wrong");
  chk_setup_set: assert property (setup_rx_i && !ctl_reset &&
    role_q == usbms_pkg::ROLE_DEV ##1 !ctl_reset |=>
    setup_pending_o[$past(setup_ep_i, 2)]) else $error("flag not set");
  chk_setup_clear: assert property (saf_wr && !setup_rx_i |=>
    ##1 (setup_pending_o & $past(bus_wdata[3:0], 2)) == 4'h0)
    else $error("flag not cleared");
  chk_dev_only_flags: assert property (!role_dev_o |->
    setup_pending_o == 4'h0) else $error("flags outside device role");
endmodule : usbms_chk
